// [sbs_defs.vh]
/*
  Constants for the synchronous burst SRAM interface: pin timing, sleep
  state codes and data lane layout.
  Assumes a 100 MHz core clock and inclusion by the design files only.
*/
`ifndef SBS_DEFS_VH
`define SBS_DEFS_VH

// Clock period in ns
`define SBS_CLK_PERIOD_NS      10
// Sleep entry and recovery, in clock periods as printed
`define SBS_SLEEP_ENTRY_TCYC   2
`define SBS_SLEEP_RECOVERY_TCYC 2
// Same figures as core cycles, sized for the two-bit phase counter
`define SBS_SLEEP_ENTRY_CYC    2'h2
`define SBS_SLEEP_EXIT_CYC     2'h2

// Sleep state machine, one-hot
`define SBS_ST_AWAKE  4'h1
`define SBS_ST_ENTER  4'h2
`define SBS_ST_SLEEP  4'h4
`define SBS_ST_EXIT   4'h8

// Data lane: eight data bits plus one parity bit
`define SBS_LANE_BITS 8

// Synchroniser vector positions
`define SBS_SYNC_SLEEP 0
`define SBS_SYNC_ORDER 1

`endif

// [sbs_burst_ctr.v]
/*
  Two-bit wraparound burst counter with linear and interleaved order.
  Assumes load and advance come from the cycle decoder on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

module sbs_burst_ctr (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // Control
  input  wire       load,
  input  wire       advance,
  input  wire [1:0] start,
  input  wire       interleaved,
  // Burst address low bits
  output wire [1:0] cur,
  output wire [1:0] nxt
);

  reg [1:0] base;
  reg [1:0] cnt;
  wire [2:0] cnt_inc;

  function [1:0] order_addr;
    input [1:0] b;
    input [1:0] c;
    input       il;
    reg   [2:0] sum;
    begin
      sum        = {1'b0, b} + {1'b0, c};
      order_addr = il ? (b ^ c) : sum[1:0];
    end
  endfunction

  // Carry dropped on purpose: the counter wraps
  assign cnt_inc = {1'b0, cnt} + 3'h1;
  assign cur = order_addr(base, cnt, interleaved);
  assign nxt = order_addr(base, cnt_inc[1:0], interleaved);

  always @(posedge clk) begin
    if (rst) begin
      base <= 2'h0;
      cnt  <= 2'h0;
    end else if (load) begin
      base <= start;
      cnt  <= 2'h0;
    end else if (advance) begin
      cnt <= cnt_inc[1:0];
    end
  end

endmodule

`default_nettype wire

// [sbs_sram.v]
/*
  Pipelined burst SRAM core: cycle decoding, burst addressing, byte lane
  writes, output drive control and sleep handling, storage in flip-flops.
  Assumes a bus master on clk that keeps the documented protocol; sleep
  request and burst order arrive asynchronously from pins.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sbs_defs.vh"

// Summary of operation
// - Sleep request is asynchronous; while high, data pins never drive.
// - Entering and leaving sleep each take two clocks after the level change; here sleep_active follows the pin on the seventh clock.
// - Array contents stay unchanged during sleep.
// - An access pending at sleep entry is abandoned as invalid.
// - Processor-strobe start is always a read; writes only on later clocks.
// - Output enable acts unclocked and is masked during writes.
// - Reads drive data only with output enable low and device selected.
// - Lane a writes bits 7..0 plus parity 0, lane b bits 15..8 plus parity 1.
// - Single-select variant uses select 1; else needs 1 low, 2 high, 3 low.
// - Burst order picks interleaved xor or linear; counter loads low address.
// - Advance low at a clock edge steps the burst counter, reads and writes.
// - All-bytes write low writes every lane; unselected lanes stay unchanged.
// - Controller-strobe write completes in the cycle it is sampled.
module sbs_sram #(
  parameter ADDR_W        = 19,
  parameter LANES         = 4,
  parameter SINGLE_SELECT = 0
) (
  // Clock and reset
  input  wire                         clk,
  input  wire                         rst,
  // Address and selects
  input  wire [ADDR_W-1:0]            addr,
  input  wire                         chip_select_1_n,
  input  wire                         chip_select_2,
  input  wire                         chip_select_3_n,
  // Strobes and burst control
  input  wire                         processor_addr_strobe_n,
  input  wire                         controller_addr_strobe_n,
  input  wire                         burst_advance_n,
  input  wire                         burst_order_interleaved,
  // Write controls
  input  wire                         all_bytes_write_n,
  input  wire                         byte_write_gate_n,
  input  wire [LANES-1:0]             lane_write_select_n,
  // Output enable and sleep
  input  wire                         output_enable_n,
  input  wire                         sleep_request,
  // Data pins
  input  wire [LANES*`SBS_LANE_BITS-1:0] data_in,
  input  wire [LANES-1:0]             parity_lines_in,
  output reg  [LANES*`SBS_LANE_BITS-1:0] data_out,
  output reg  [LANES-1:0]             parity_lines_out,
  output wire                         data_oe,
  // Status
  output reg                          sleep_active
);

  localparam DW    = LANES * (`SBS_LANE_BITS + 1);
  localparam DEPTH = 1 << ADDR_W;

  reg  [DW-1:0]     mem [0:DEPTH-1];
  reg  [2:0]        sync_sleep;
  reg  [2:0]        sync_order;
  reg               sleep_lvl;
  reg               order_lvl;
  reg  [3:0]        state;
  reg  [1:0]        cnt;
  reg               active;
  reg               rd_q;
  reg               drive;
  reg  [ADDR_W-1:0] hi_q;
  reg  [ADDR_W-1:0] rd_idx;
  reg               sel;
  reg               processor_addr_strobe_n_eff;
  reg               strobe;
  reg  [LANES-1:0]  lanes_we;
  reg               wr_req;
  reg               do_desel;
  reg               do_begin;
  reg               do_cont;
  reg               do_susp;
  reg               do_write;
  reg  [ADDR_W-1:0] idx;
  wire [1:0]        burst_cur;
  wire [1:0]        burst_nxt;
  wire              awake;
  wire [2:0]        cnt_inc;
  integer           i;

  assign awake = (state == `SBS_ST_AWAKE);
  assign cnt_inc = {1'b0, cnt} + 3'h1;

  assign data_oe = drive & ~output_enable_n & ~sleep_request;

  // Third and second stage must agree before a change counts
  always @(posedge clk) begin
    if (rst) begin
      sync_sleep <= 3'h0;
      sync_order <= 3'h0;
      sleep_lvl  <= 1'b0;
      order_lvl  <= 1'b0;
    end else begin
      sync_sleep <= {sync_sleep[1:0], sleep_request};
      sync_order <= {sync_order[1:0], burst_order_interleaved};
      if (sync_sleep[2] == sync_sleep[1]) begin
        sleep_lvl <= sync_sleep[2];
      end
      if (sync_order[2] == sync_order[1]) begin
        order_lvl <= sync_order[2];
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      state        <= `SBS_ST_AWAKE;
      cnt          <= 2'h0;
      sleep_active <= 1'b0;
    end else begin
      case (state)
        `SBS_ST_AWAKE: begin
          if (sleep_lvl) begin
            state <= `SBS_ST_ENTER;
            cnt   <= 2'h1;
          end
        end
        `SBS_ST_ENTER: begin
          if (!sleep_lvl) begin
            state <= `SBS_ST_EXIT;
            cnt   <= 2'h1;
          end else if (cnt == `SBS_SLEEP_ENTRY_CYC) begin
            state        <= `SBS_ST_SLEEP;
            sleep_active <= 1'b1;
          end else begin
            cnt <= cnt_inc[1:0];
          end
        end
        `SBS_ST_SLEEP: begin
          if (!sleep_lvl) begin
            state <= `SBS_ST_EXIT;
            cnt   <= 2'h1;
          end
        end
        `SBS_ST_EXIT: begin
          if (cnt == `SBS_SLEEP_EXIT_CYC) begin
            state        <= `SBS_ST_AWAKE;
            sleep_active <= 1'b0;
          end else begin
            cnt <= cnt_inc[1:0];
          end
        end
        default: begin
          state        <= `SBS_ST_AWAKE;
          sleep_active <= 1'b0;
        end
      endcase
    end
  end

  always @* begin
    sel = ~chip_select_1_n &
          ((SINGLE_SELECT != 0) | (chip_select_2 & ~chip_select_3_n));
    processor_addr_strobe_n_eff = ~processor_addr_strobe_n & ~chip_select_1_n;
    strobe   = processor_addr_strobe_n_eff | ~controller_addr_strobe_n;
    if (!all_bytes_write_n) begin
      lanes_we = {LANES{1'b1}};
    end else if (!byte_write_gate_n) begin
      lanes_we = ~lane_write_select_n;
    end else begin
      lanes_we = {LANES{1'b0}};
    end
    wr_req   = |lanes_we;
    do_desel = 1'b0;
    do_begin = 1'b0;
    do_cont  = 1'b0;
    do_susp  = 1'b0;
    do_write = 1'b0;
    idx      = {hi_q[ADDR_W-1:2], burst_cur};
    if (!awake) begin
      do_desel = 1'b0;
    end else if (strobe && !sel) begin
      do_desel = 1'b1;
    end else if (strobe) begin
      do_begin = 1'b1;
      idx      = addr;
      do_write = ~processor_addr_strobe_n_eff & wr_req;
    end else if (active) begin
      do_cont  = ~burst_advance_n;
      do_susp  = burst_advance_n;
      do_write = wr_req;
      if (!burst_advance_n) begin
        idx = {hi_q[ADDR_W-1:2], burst_nxt};
      end
    end
  end

  sbs_burst_ctr u_burst (
    .clk         (clk),
    .rst         (rst),
    .load        (do_begin),
    .advance     (do_cont),
    .start       (addr[1:0]),
    .interleaved (order_lvl),
    .cur         (burst_cur),
    .nxt         (burst_nxt)
  );

  always @(posedge clk) begin
    if (rst) begin
      active           <= 1'b0;
      rd_q             <= 1'b0;
      drive            <= 1'b0;
      hi_q             <= {ADDR_W{1'b0}};
      rd_idx           <= {ADDR_W{1'b0}};
      data_out         <= {(LANES*`SBS_LANE_BITS){1'b0}};
      parity_lines_out <= {LANES{1'b0}};
    end else begin
      {parity_lines_out, data_out} <= mem[rd_idx];
      rd_idx <= idx;
      if (!awake || do_desel) begin
        active <= 1'b0;
        rd_q   <= 1'b0;
        drive  <= 1'b0;
      end else if (do_begin || do_cont || do_susp) begin
        active <= 1'b1;
        rd_q   <= ~do_write;
        // First cycle after deselect stays three-stated
        drive  <= rd_q & ~do_write;
        if (do_begin) begin
          hi_q <= addr;
        end
      end else begin
        rd_q  <= 1'b0;
        drive <= 1'b0;
      end
    end
  end

  // Array has no reset so contents survive everything but writes
  always @(posedge clk) begin
    if (!rst && awake && do_write) begin
      for (i = 0; i < LANES; i = i + 1) begin
        if (lanes_we[i]) begin
          mem[idx][i*`SBS_LANE_BITS +: `SBS_LANE_BITS] <=
            data_in[i*`SBS_LANE_BITS +: `SBS_LANE_BITS];
          mem[idx][LANES*`SBS_LANE_BITS + i] <= parity_lines_in[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

// [sbs_sram_checker.sv]
/* Pin assertions for the burst SRAM core.
   Bound to sbs_sram, sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module sbs_sram_checker #(parameter LANES = 4) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus inputs
  input wire logic chip_select_1_n,
  input wire logic chip_select_2,
  input wire logic chip_select_3_n,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic all_bytes_write_n,
  input wire logic byte_write_gate_n,
  input wire logic [LANES-1:0] lane_write_select_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  // Outputs
  input wire logic data_oe,
  input wire logic sleep_active
);
  wire logic sel = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  wire logic stb = !controller_addr_strobe_n || (!processor_addr_strobe_n && !chip_select_1_n);
  wire logic rd = all_bytes_write_n && (byte_write_gate_n || &lane_write_select_n);
  wire logic idl = processor_addr_strobe_n && controller_addr_strobe_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_SLEEP_MASK: assert property (sleep_request |-> !data_oe)
    else $error("drive under sleep");
  AST_SLEEP_ENTRY: assert property (sleep_request [*8] |-> sleep_active)
    else $error("sleep not reached");
  AST_ASLEEP_OFF: assert property (sleep_active |-> !data_oe)
    else $error("drive while asleep");
  AST_OE_OFF: assert property (output_enable_n |-> !data_oe)
    else $error("drive with enable off");
  AST_WRITE_OFF:
    assert property (!rd && (idl || (sel && processor_addr_strobe_n && !controller_addr_strobe_n))
      |=> !data_oe) else $error("drive in write");
  AST_DESEL_OFF: assert property (stb && !sel |=> !data_oe)
    else $error("drive after deselect");
  AST_FIRST_OFF:
    assert property (stb && !sel ##1 stb && sel |=> !data_oe) else $error("drive in first read");
  AST_READ_ON:
    assert property (stb && sel && (rd || !processor_addr_strobe_n) && !sleep_active ##1 idl && rd
      |=> data_oe == !output_enable_n) else $error("read not driven");
endmodule
bind sbs_sram sbs_sram_checker #(.LANES(LANES)) chk_u (.*);
`default_nettype wire

// [sbs_master.sv]
/* Bus master model for the burst SRAM core.
   Tasks start at a falling clock edge; bus returns at the next one, sleep after n or n+1. */
`timescale 1ns/100ps
`default_nettype none
module sbs_master (
  // Clock
  input wire logic clk,
  // Pins towards the memory
  output logic [5:0] addr,
  output logic chip_select_1_n,
  output logic chip_select_2,
  output logic chip_select_3_n,
  output logic processor_addr_strobe_n,
  output logic controller_addr_strobe_n,
  output logic burst_advance_n,
  output logic all_bytes_write_n,
  output logic byte_write_gate_n,
  output logic [3:0] lane_write_select_n,
  output logic output_enable_n,
  output logic sleep_request,
  output logic [31:0] data_in,
  output logic [3:0] parity_lines_in
);
  initial sleep_request = 1'b0;
  // One clock of bus activity; k names the select held false, 0 for none
  task automatic bus(input [1:0] k, input ps, cs, av, g, be, input [3:0] bw,
                     input [5:0] a, input [35:0] d);
    {chip_select_1_n, chip_select_2, chip_select_3_n} = {k == 1, k != 2, k == 3};
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = {ps, cs, av};
    {all_bytes_write_n, byte_write_gate_n, lane_write_select_n, addr} = {g, be, bw, a};
    output_enable_n = !(g && (be || &bw));
    // Released bus changes every cycle so stale data cannot match
    {parity_lines_in, data_in} = output_enable_n ? d : {4'($urandom), $urandom};
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic sleep(input v, input int n);
    if (v) bus(1, 1, 0, 1, 1, 1, 4'hf, 0, 0);
    sleep_request = v;
    repeat (n) bus(1, 1, 1, 1, 1, 1, 4'hf, 0, 0);
  endtask
endmodule
`default_nettype wire

// [test_sync_burst_sram_interface.sv]
/* Bench for the burst SRAM core: model array compared at every read.
   Pins driven by sbs_master; 100 MHz clock, sync reset. */
`timescale 1ns/100ps
`default_nettype none
module test_sync_burst_sram_interface;
  logic clk, rst, burst_order_interleaved = 1'b0;
  logic [5:0] addr, a;
  logic chip_select_1_n, chip_select_2, chip_select_3_n, processor_addr_strobe_n;
  logic controller_addr_strobe_n, burst_advance_n, all_bytes_write_n, byte_write_gate_n;
  logic output_enable_n, sleep_request, data_oe, sleep_active;
  logic [3:0] lane_write_select_n, parity_lines_in, parity_lines_out;
  logic [31:0] data_in, data_out;
  logic [35:0] m [64];
  logic [35:0] r;
  int failures = 0, total_checks = 0;
  sbs_sram #(.ADDR_W(6)) dut_u (.*);
  sbs_master m_u (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [35:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input [5:0] wa, input g, be, input [3:0] bw, input c);
    logic [35:0] d;
    d = {4'($urandom), $urandom};
    m_u.bus(0, 1, c, 1, g, be, bw, wa, d);
    for (int l = 0; l < 4; l++)
      if (!g || (!be && !bw[l])) begin
        m[wa][8*l+:8] = d[8*l+:8];
        m[wa][32+l] = d[32+l];
      end
  endtask
  task automatic desel;
    logic [1:0] k;
    k = 2'(1 + $urandom % 3);
    m_u.bus(k, k == 1, k != 1, 1, 1, 1, 4'hf, 0, 0);
  endtask
  // burst walk in the selected order
  task automatic rd(input [5:0] ra);
    logic [5:0] p;
    logic [1:0] c;
    bit v;
    c = 0;
    p = ra;
    // Either strobe may open a read
    v = 1'($urandom);
    m_u.bus(0, v, !v, 1, 1, 1, 4'hf, ra, 0);
    for (int j = 0; j < 5; j++) begin
      v = 1'($urandom);
      if (j < 4) m_u.bus(0, 1, 1, v, 1, 1, 4'hf, 0, 0);
      else desel;
      check("read data", {parity_lines_out, data_out}, m[p]);
      check("read drive", data_oe, j < 4);
      c += 2'(!v);
      p = {ra[5:2], burst_order_interleaved ? ra[1:0] ^ c : ra[1:0] + c};
    end
  endtask
  initial begin
    #100us;
    failures++;
    summarize;
  end
  initial begin
    void'($urandom(34));
    rst = 1'b1;
    repeat (8) m_u.bus(1, 1, 1, 1, 1, 1, 4'hf, 0, 0);
    rst = 1'b0;
    for (int i = 0; i < 64; i++) wr(6'(i), 0, 1, 4'hf, 0);
    repeat (24) wr(6'($urandom), 1, 1'($urandom), 4'($urandom), 0);
    a = 6'($urandom);
    m_u.bus(0, 0, 1, 1, 0, 1, 4'hf, a, 0);
    wr(a, 1, 0, 4'he, 1);
    // continue write lands on the next linear address
    r = {4'($urandom), $urandom};
    m_u.bus(0, 1, 1, 0, 0, 1, 4'hf, 0, r);
    m[{a[5:2], 2'(a[1:0] + 2'h1)}] = r;
    desel;
    rd(a);
    rd({a[5:2], 2'(a[1:0] + 2'h1)});
    for (int o = 0; o < 2; o++) begin
      burst_order_interleaved = o[0];
      repeat (4) desel;
      repeat (12) rd(6'($urandom));
    end
    // array kept, access refused in sleep
    m_u.sleep(1, 10);
    check("sleep state", sleep_active, 1);
    a = 6'($urandom);
    r = m[a];
    wr(a, 0, 1, 4'hf, 0);
    m[a] = r;
    m_u.sleep(0, 10);
    check("sleep state", sleep_active, 0);
    rd(a);
    summarize;
  end
endmodule
`default_nettype wire
